// ---- fdr_top.v ----
// drive fault reaction: reaction-code objects, ramp selection and drive state changes
`timescale 1ns/1ps
`include "fdr_defines.vh"

module fdr_top #(
  parameter DECEL_W = 32
) (
  clk,
  rstn,
  od_wr_en,
  od_rd_en,
  od_index,
  od_wdata,
  od_rdata_q,
  od_ack_q,
  od_err_q,
  dev_err_evt,
  limit_pass_evt,
  ctrl_word,
  mode_decel,
  quick_decel,
  ramp_done,
  reenable,
  warn_clr,
  drive_state_q,
  ramp_en_q,
  ramp_decel_q,
  drive_block_q,
  motor_energized_q,
  status_warn_q
);
  input wire clk;
  input wire rstn;
  input wire od_wr_en;
  input wire od_rd_en;
  input wire [15:0] od_index;
  input wire [15:0] od_wdata;
  output reg [15:0] od_rdata_q;
  output reg od_ack_q;
  output reg od_err_q;
  input wire dev_err_evt;
  input wire limit_pass_evt;
  input wire [15:0] ctrl_word;
  input wire [DECEL_W-1:0] mode_decel;
  input wire [DECEL_W-1:0] quick_decel;
  input wire ramp_done;
  input wire reenable;
  input wire warn_clr;
  output reg [2:0] drive_state_q;
  output reg ramp_en_q;
  output reg [DECEL_W-1:0] ramp_decel_q;
  output reg drive_block_q;
  output reg motor_energized_q;
  output reg status_warn_q;

  // ==========================================================
  // object access
  wire hit_dev;
  wire hit_lim;
  wire [15:0] dev_code;
  wire [15:0] lim_code;
  wire [1:0] dev_ramp;
  wire [1:0] dev_tgt;
  wire [1:0] lim_ramp;
  wire [1:0] lim_tgt;

  assign hit_dev = (od_index == `FDR_IDX_DEV_CODE);
  assign hit_lim = (od_index == `FDR_IDX_LIM_CODE);

  // deviation code resets to a reserved value, so coasting is assumed until a valid write
  fdr_code_reg #(
    .IS_LIMIT(0),
    .ACT_RESET({`FDR_RAMP_COAST, `FDR_TGT_STAY})
  ) u_dev_code (
    .clk(clk),
    .rstn(rstn),
    .wr_en(od_wr_en & hit_dev),
    .wdata(od_wdata),
    .code_q(dev_code),
    .ramp_q(dev_ramp),
    .tgt_q(dev_tgt)
  );

  fdr_code_reg #(
    .IS_LIMIT(1),
    .ACT_RESET({`FDR_RAMP_NONE, `FDR_TGT_STAY})
  ) u_lim_code (
    .clk(clk),
    .rstn(rstn),
    .wr_en(od_wr_en & hit_lim),
    .wdata(od_wdata),
    .code_q(lim_code),
    .ramp_q(lim_ramp),
    .tgt_q(lim_tgt)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      od_rdata_q <= 16'h0000;
      od_ack_q <= 1'b0;
      od_err_q <= 1'b0;
    end else begin
      od_ack_q <= od_wr_en | od_rd_en;
      od_err_q <= (od_wr_en | od_rd_en) & ~hit_dev & ~hit_lim;
      if (od_rd_en) begin
        if (hit_dev) begin
          od_rdata_q <= dev_code;
        end else if (hit_lim) begin
          od_rdata_q <= lim_code;
        end else begin
          od_rdata_q <= 16'h0000;
        end
      end
    end
  end

  // ==========================================================
  // reaction selection
  // a deviation error outranks a limit pass in the same cycle
  reg [2:0] state_d;
  reg [1:0] tgt_q;
  reg [1:0] tgt_d;
  reg ramp_en_d;
  reg [DECEL_W-1:0] ramp_decel_d;
  reg qs_low_seen_q;
  reg qs_low_seen_d;
  reg [1:0] sel_ramp;
  reg [1:0] sel_tgt;
  reg sel_evt;

  always @* begin
    sel_evt = 1'b0;
    sel_ramp = `FDR_RAMP_NONE;
    sel_tgt = `FDR_TGT_STAY;
    if (dev_err_evt) begin
      sel_evt = 1'b1;
      sel_ramp = dev_ramp;
      sel_tgt = dev_tgt;
    end else if (limit_pass_evt) begin
      sel_evt = 1'b1;
      sel_ramp = lim_ramp;
      sel_tgt = lim_tgt;
    end
  end

  // ==========================================================
  // drive state machine
  always @* begin
    state_d = drive_state_q;
    tgt_d = tgt_q;
    ramp_en_d = ramp_en_q;
    ramp_decel_d = ramp_decel_q;
    qs_low_seen_d = qs_low_seen_q;
    case (drive_state_q)
      `FDR_ST_RUN: begin
        if (sel_evt) begin
          case (sel_ramp)
            `FDR_RAMP_COAST: begin
              state_d = `FDR_ST_COAST;
              ramp_en_d = 1'b0;
            end
            `FDR_RAMP_SLOW: begin
              state_d = `FDR_ST_RAMP;
              tgt_d = sel_tgt;
              ramp_en_d = 1'b1;
              ramp_decel_d = mode_decel;
            end
            `FDR_RAMP_QUICK: begin
              state_d = `FDR_ST_RAMP;
              tgt_d = sel_tgt;
              ramp_en_d = 1'b1;
              ramp_decel_d = quick_decel;
            end
            default: state_d = `FDR_ST_RUN;
          endcase
        end
      end
      `FDR_ST_RAMP: begin
        // a coasting deviation reaction cuts an active ramp short
        if (dev_err_evt && dev_ramp == `FDR_RAMP_COAST) begin
          state_d = `FDR_ST_COAST;
          ramp_en_d = 1'b0;
        end else if (ramp_done) begin
          ramp_en_d = 1'b0;
          case (tgt_q)
            `FDR_TGT_SOD: state_d = `FDR_ST_SOD;
            `FDR_TGT_QSA: begin
              state_d = `FDR_ST_QSA;
              qs_low_seen_d = 1'b0;
            end
            default: state_d = `FDR_ST_HALT;
          endcase
        end
      end
      `FDR_ST_QSA: begin
        // the quick-stop bit is left alone; only a 0 then 1 from the master releases
        if (!ctrl_word[`FDR_CW_QS_BIT]) begin
          qs_low_seen_d = 1'b1;
        end else if (qs_low_seen_q) begin
          state_d = `FDR_ST_RUN;
          qs_low_seen_d = 1'b0;
        end
      end
      `FDR_ST_COAST, `FDR_ST_SOD, `FDR_ST_HALT: begin
        if (reenable) begin
          state_d = `FDR_ST_RUN;
        end
      end
      default: begin
        state_d = `FDR_ST_RUN;
        ramp_en_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      drive_state_q <= `FDR_ST_RUN;
      tgt_q <= `FDR_TGT_STAY;
      ramp_en_q <= 1'b0;
      ramp_decel_q <= {DECEL_W{1'b0}};
      qs_low_seen_q <= 1'b0;
      drive_block_q <= 1'b0;
      motor_energized_q <= 1'b1;
      status_warn_q <= 1'b0;
    end else begin
      drive_state_q <= state_d;
      tgt_q <= tgt_d;
      ramp_en_q <= ramp_en_d;
      ramp_decel_q <= ramp_decel_d;
      qs_low_seen_q <= qs_low_seen_d;
      // blocked drive: no torque, motor turns freely
      drive_block_q <= (state_d == `FDR_ST_COAST);
      // quick stop active keeps the power stage on
      motor_energized_q <= (state_d == `FDR_ST_RUN) || (state_d == `FDR_ST_RAMP) ||
                           (state_d == `FDR_ST_QSA) || (state_d == `FDR_ST_HALT);
      // set wins over clear so a pass in the clearing cycle is not lost
      if (limit_pass_evt) begin
        status_warn_q <= 1'b1;
      end else if (warn_clr) begin
        status_warn_q <= 1'b0;
      end
    end
  end
endmodule

// ---- fdr_defines.vh ----
// constants for the drive fault reaction block
// Notes on behaviour
// - deviation error runs selected deviation reaction
// - deviation code 0: block drive, coast
// - deviation code 1: slow-down ramp, mode decel
// - deviation code 2: quick-stop ramp, quick decel
// - limit pass sets warning bit 7, reacts
// - limit code -1: no stopping action
// - limit code 1: slow ramp, then switch-on-disabled
// - limit code 2: quick ramp, then switch-on-disabled
// - limit code 5: slow ramp, then quick-stop-active
// - limit code 6: quick ramp, then quick-stop-active
// - quick-stop bit untouched; master writes 0 then 1
`ifndef FDR_DEFINES_VH
`define FDR_DEFINES_VH

// ==========================================================
// object indices and reset values
`define FDR_IDX_DEV_CODE 16'h3700
`define FDR_IDX_LIM_CODE 16'h3701
`define FDR_CODE_RESET 16'hFFFF

// ==========================================================
// reaction code values
`define FDR_CODE_M1 16'hFFFF
`define FDR_CODE_0 16'h0000
`define FDR_CODE_1 16'h0001
`define FDR_CODE_2 16'h0002
`define FDR_CODE_5 16'h0005
`define FDR_CODE_6 16'h0006

// ==========================================================
// decoded action: ramp kind and final state
`define FDR_RAMP_NONE 2'h0
`define FDR_RAMP_COAST 2'h1
`define FDR_RAMP_SLOW 2'h2
`define FDR_RAMP_QUICK 2'h3
`define FDR_TGT_STAY 2'h0
`define FDR_TGT_SOD 2'h1
`define FDR_TGT_QSA 2'h2
`define FDR_TGT_HALT 2'h3

// ==========================================================
// drive state codes
`define FDR_ST_RUN 3'h0
`define FDR_ST_RAMP 3'h1
`define FDR_ST_COAST 3'h2
`define FDR_ST_SOD 3'h3
`define FDR_ST_QSA 3'h4
`define FDR_ST_HALT 3'h5

// ==========================================================
// control and status word bits
`define FDR_CW_QS_BIT 2
`define FDR_SW_WARN_BIT 7

`endif

// ---- fdr_code_reg.v ----
// one reaction-code object: stored value plus last valid decoded action
`timescale 1ns/1ps
`include "fdr_defines.vh"

module fdr_code_reg #(
  parameter IS_LIMIT = 0,
  parameter [3:0] ACT_RESET = {`FDR_RAMP_NONE, `FDR_TGT_STAY}
) (
  clk,
  rstn,
  wr_en,
  wdata,
  code_q,
  ramp_q,
  tgt_q
);
  input wire clk;
  input wire rstn;
  input wire wr_en;
  input wire [15:0] wdata;
  output reg [15:0] code_q;
  output reg [1:0] ramp_q;
  output reg [1:0] tgt_q;

  // returns {valid, ramp, target}
  function [4:0] decode;
    input lim;
    input [15:0] c;
    begin
      decode = 5'h00;
      if (lim) begin
        case (c)
          `FDR_CODE_M1: decode = {1'b1, `FDR_RAMP_NONE, `FDR_TGT_STAY};
          `FDR_CODE_1: decode = {1'b1, `FDR_RAMP_SLOW, `FDR_TGT_SOD};
          `FDR_CODE_2: decode = {1'b1, `FDR_RAMP_QUICK, `FDR_TGT_SOD};
          `FDR_CODE_5: decode = {1'b1, `FDR_RAMP_SLOW, `FDR_TGT_QSA};
          `FDR_CODE_6: decode = {1'b1, `FDR_RAMP_QUICK, `FDR_TGT_QSA};
          default: decode = 5'h00;
        endcase
      end else begin
        case (c)
          `FDR_CODE_0: decode = {1'b1, `FDR_RAMP_COAST, `FDR_TGT_STAY};
          `FDR_CODE_1: decode = {1'b1, `FDR_RAMP_SLOW, `FDR_TGT_HALT};
          `FDR_CODE_2: decode = {1'b1, `FDR_RAMP_QUICK, `FDR_TGT_HALT};
          default: decode = 5'h00;
        endcase
      end
    end
  endfunction

  wire [4:0] dec;
  assign dec = decode(IS_LIMIT != 0, wdata);

  always @(posedge clk) begin
    if (!rstn) begin
      code_q <= `FDR_CODE_RESET;
      ramp_q <= ACT_RESET[3:2];
      tgt_q <= ACT_RESET[1:0];
    end else if (wr_en) begin
      // the object keeps what was written; only a defined code changes behaviour
      code_q <= wdata;
      if (dec[4]) begin
        ramp_q <= dec[3:2];
        tgt_q <= dec[1:0];
      end
    end
  end
endmodule

// ---- fdr_sva.sv ----
// checker for the drive fault reaction top
`timescale 1ns/1ps
`include "fdr_defines.vh"
module fdr_sva #(
  parameter DECEL_W = 32
) (
  input wire clk,
  input wire rstn,
  input wire dev_err_evt,
  input wire limit_pass_evt,
  input wire [15:0] ctrl_word,
  input wire ramp_done,
  input wire [2:0] drive_state_q,
  input wire ramp_en_q,
  input wire [DECEL_W-1:0] ramp_decel_q,
  input wire drive_block_q,
  input wire motor_energized_q,
  input wire status_warn_q
);
  localparam [2:0] RUN = `FDR_ST_RUN;
  localparam [2:0] RAMP = `FDR_ST_RAMP;
  localparam [2:0] COAST = `FDR_ST_COAST;
  localparam [2:0] SOD = `FDR_ST_SOD;
  localparam [2:0] QSA = `FDR_ST_QSA;
  wire [2:0] s = drive_state_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_BLOCK: assert property (drive_block_q == (s == COAST))
    else $error("block flag off");
  AST_COAST_CAUSE: assert property ((s != COAST ##1 s == COAST) |-> $past(dev_err_evt))
    else $error("coast without error");
  AST_RAMP_EN: assert property (ramp_en_q == (s == RAMP))
    else $error("ramp enable off");
  AST_RAMP_HOLD: assert property (s == RAMP && !ramp_done && !dev_err_evt |=> s == RAMP && $stable(ramp_decel_q))
    else $error("ramp left early");
  AST_WARN: assert property (limit_pass_evt |=> status_warn_q)
    else $error("warning not set");
  AST_SOD_OFF: assert property (s == SOD |-> !motor_energized_q)
    else $error("energized in sod");
  AST_QSA_ON: assert property (s == QSA |-> motor_energized_q)
    else $error("not energized in qsa");
  AST_QSA_HOLD: assert property (s == QSA && !ctrl_word[`FDR_CW_QS_BIT] |=> s == QSA)
    else $error("qsa left on low bit");
  AST_QSA_EXIT: assert property ((s == QSA ##1 s != QSA) |-> s == RUN && $past(ctrl_word[`FDR_CW_QS_BIT]))
    else $error("bad qsa exit");
endmodule
bind fdr_top fdr_sva #(.DECEL_W(DECEL_W)) u_fdr_sva (.clk(clk), .rstn(rstn), .dev_err_evt(dev_err_evt),
  .limit_pass_evt(limit_pass_evt), .ctrl_word(ctrl_word), .ramp_done(ramp_done), .drive_state_q(drive_state_q),
  .ramp_en_q(ramp_en_q), .ramp_decel_q(ramp_decel_q), .drive_block_q(drive_block_q),
  .motor_energized_q(motor_energized_q), .status_warn_q(status_warn_q));

// ---- fdr_master.sv ----
// fieldbus master model: object accesses and control word
`timescale 1ns/1ps
`include "fdr_defines.vh"
module fdr_master (
  input wire clk,
  output reg od_wr_en,
  output reg od_rd_en,
  output reg [15:0] od_index,
  output reg [15:0] od_wdata,
  input wire [15:0] od_rdata_q,
  input wire od_ack_q,
  input wire od_err_q,
  output reg [15:0] ctrl_word
);
  initial begin
    {od_wr_en, od_rd_en} = 2'h0;
    {od_index, od_wdata} = 32'h00000000;
    ctrl_word = 16'h0004;
  end
  // index and data scrambled after the strobe so nothing leans on stale values
  task xfer(input w, input [15:0] i, input [15:0] d, output [15:0] q, output [1:0] ae);
    begin
      @(negedge clk);
      {od_wr_en, od_rd_en} = {w, !w};
      {od_index, od_wdata} = {i, d};
      @(negedge clk);
      {od_wr_en, od_rd_en} = 2'h0;
      {od_index, od_wdata} = {~i, ~d};
      q = od_rdata_q;
      ae = {od_ack_q, od_err_q};
    end
  endtask
  task qs(input b);
    begin
      @(negedge clk);
      ctrl_word[`FDR_CW_QS_BIT] = b;
    end
  endtask
endmodule

// ---- fdr_top_bench.sv ----
// self-checking bench for the drive fault reaction top
`timescale 1ns/1ps
`include "fdr_defines.vh"
module fdr_top_bench;
  localparam [31:0] MD = 32'h00001234;
  localparam [31:0] QD = 32'h0000ABCD;
  reg clk, rstn, de, lp, rdn, ren, wc;
  wire wr, rd, ack, err, blk, rmp, en, warn;
  wire [15:0] idx, wd, rq, cw;
  wire [2:0] st;
  wire [31:0] dec;
  reg [15:0] q;
  reg [1:0] ae;
  integer err_count = 0;
  integer n_tests = 0;
  fdr_master u_fdr_master (.clk(clk), .od_wr_en(wr), .od_rd_en(rd), .od_index(idx), .od_wdata(wd),
    .od_rdata_q(rq), .od_ack_q(ack), .od_err_q(err), .ctrl_word(cw));
  fdr_top #(.DECEL_W(32)) u_fdr_top (.clk(clk), .rstn(rstn), .od_wr_en(wr), .od_rd_en(rd), .od_index(idx),
    .od_wdata(wd), .od_rdata_q(rq), .od_ack_q(ack), .od_err_q(err), .dev_err_evt(de), .limit_pass_evt(lp),
    .ctrl_word(cw), .mode_decel(MD), .quick_decel(QD), .ramp_done(rdn), .reenable(ren), .warn_clr(wc),
    .drive_state_q(st), .ramp_en_q(rmp), .ramp_decel_q(dec), .drive_block_q(blk), .motor_energized_q(en),
    .status_warn_q(warn));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task obj(input w, input [15:0] i, input [15:0] d, input [1:0] xae);
    begin
      u_fdr_master.xfer(w, i, d, q, ae);
      chk(ae, xae);
      if (!w)
        chk(q, d);
    end
  endtask
  task react(input lim, input [15:0] code, input [2:0] s1, input [2:0] fin, input [31:0] xdec);
    reg [15:0] i;
    begin
      i = lim ? `FDR_IDX_LIM_CODE : `FDR_IDX_DEV_CODE;
      obj(1'h1, i, code, 2'h2);
      obj(1'h0, i, code, 2'h2);
      @(negedge clk);
      {lp, de} = {lim, !lim};
      @(negedge clk);
      {lp, de} = 2'h0;
      chk(st, s1);
      chk(warn, lim);
      if (s1 == `FDR_ST_RAMP) begin
        chk(dec, xdec);
        chk(rmp, 1'h1);
        rdn = 1'h1;
        @(negedge clk);
        rdn = 1'h0;
        chk(rmp, 1'h0);
      end
      chk(st, fin);
      chk(en, fin != `FDR_ST_SOD && fin != `FDR_ST_COAST);
      chk(blk, fin == `FDR_ST_COAST);
      wc = 1'h1;
      @(negedge clk);
      wc = 1'h0;
      chk(warn, 1'h0);
      if (fin == `FDR_ST_QSA) begin
        u_fdr_master.qs(1'h0);
        u_fdr_master.qs(1'h1);
        chk(st, fin);
        @(negedge clk);
      end else begin
        ren = 1'h1;
        @(negedge clk);
        ren = 1'h0;
      end
      chk(st, `FDR_ST_RUN);
    end
  endtask
  task t_reset;
    begin
      chk(en, 1'h1);
      obj(1'h0, `FDR_IDX_DEV_CODE, 16'hFFFF, 2'h2);
      obj(1'h0, `FDR_IDX_LIM_CODE, 16'hFFFF, 2'h2);
      // reset deviation code is reserved, so the block coasts until a valid write
      de = 1'h1;
      @(negedge clk);
      de = 1'h0;
      chk(st, `FDR_ST_COAST);
      chk(en, 1'h0);
      chk(warn, 1'h0);
      ren = 1'h1;
      @(negedge clk);
      ren = 1'h0;
      chk(st, `FDR_ST_RUN);
      obj(1'h1, 16'h3702, 16'h0005, 2'h3);
      obj(1'h0, 16'h3702, 16'h0000, 2'h3);
    end
  endtask
  task t_dev;
    begin
      react(1'h0, 16'h0000, `FDR_ST_COAST, `FDR_ST_COAST, 32'h0);
      react(1'h0, 16'h0001, `FDR_ST_RAMP, `FDR_ST_HALT, MD);
      react(1'h0, 16'h0002, `FDR_ST_RAMP, `FDR_ST_HALT, QD);
      react(1'h0, 16'h0003, `FDR_ST_RAMP, `FDR_ST_HALT, QD);
    end
  endtask
  task t_lim;
    begin
      react(1'h1, 16'hFFFF, `FDR_ST_RUN, `FDR_ST_RUN, 32'h0);
      react(1'h1, 16'h0001, `FDR_ST_RAMP, `FDR_ST_SOD, MD);
      react(1'h1, 16'h0002, `FDR_ST_RAMP, `FDR_ST_SOD, QD);
      react(1'h1, 16'h0004, `FDR_ST_RAMP, `FDR_ST_SOD, QD);
      react(1'h1, 16'h0005, `FDR_ST_RAMP, `FDR_ST_QSA, MD);
      react(1'h1, 16'h0006, `FDR_ST_RAMP, `FDR_ST_QSA, QD);
    end
  endtask
  // a coasting deviation reaction must cut a running limit ramp short
  task t_cut;
    begin
      obj(1'h1, `FDR_IDX_DEV_CODE, 16'h0000, 2'h2);
      @(negedge clk);
      lp = 1'h1;
      @(negedge clk);
      lp = 1'h0;
      chk(st, `FDR_ST_RAMP);
      de = 1'h1;
      @(negedge clk);
      de = 1'h0;
      chk(st, `FDR_ST_COAST);
      chk(rmp, 1'h0);
      chk(blk, 1'h1);
      ren = 1'h1;
      @(negedge clk);
      ren = 1'h0;
      chk(st, `FDR_ST_RUN);
    end
  endtask
  initial begin
    {rstn, de, lp, rdn, ren, wc} = 6'h00;
    repeat (5) @(negedge clk);
    rstn = 1'h1;
    t_reset;
    t_dev;
    t_lim;
    t_cut;
    results;
  end
  initial begin
    #40000;
    err_count = err_count + 1;
    results;
  end
endmodule
